/* logic/arc_zone_pkg.sv */
package arc_zone_pkg;
  localparam int NZONE = 4;
  localparam int NCHAN = 4;
  localparam int DW = 32;
  localparam int AW = 8;
  // register byte addresses
  localparam logic [AW-1:0] A_ZONE_EN = 8'h00;
  localparam logic [AW-1:0] A_ZONE_CFG [NZONE] = '{8'h04, 8'h08, 8'h0C, 8'h10};
  localparam logic [AW-1:0] A_CHAN_CFG = 8'h14;
  localparam logic [AW-1:0] A_ON_SEL = 8'h18;
  localparam logic [AW-1:0] A_OFF_SEL = 8'h1C;
  localparam logic [AW-1:0] A_EVT_CNT = 8'h20;
  localparam logic [AW-1:0] A_STATUS = 8'h24;
  localparam logic [AW-1:0] A_HIST_SEL = 8'h28;
  localparam logic [AW-1:0] A_HIST_TS = 8'h2C;
  localparam logic [AW-1:0] A_HIST_AB = 8'h30;
  localparam logic [AW-1:0] A_HIST_CR = 8'h34;
  localparam logic [AW-1:0] A_HIST_MISC = 8'h38;
  // zone configuration fields
  localparam int F_PH = 0;
  localparam int F_RES = 1;
  localparam int F_LIGHT = 2;
  localparam int F_PRES = 6;
  localparam int F_AUX = 10;
  localparam int AUX_W = 2;
  localparam int CFG_W = 12;
  typedef enum logic [AUX_W-1:0] {AUX_OFF, AUX_LIGHT, AUX_CUR} aux_mode_e;
  // monitored status / event code layout
  localparam int EV_TRIP = 0;
  localparam int EV_BLK = 4;
  localparam int EV_PH_BLK = 8;
  localparam int EV_PH_START = 9;
  localparam int EV_RES_BLK = 10;
  localparam int EV_RES_START = 11;
  localparam int EV_LIGHT = 12;
  localparam int EV_PRES = 16;
  localparam int EV_AUX = 20;
  localparam int EV_SFAULT = 21;
  localparam int EV_IOFAULT = 25;
  localparam int EV_W = 26;
  localparam int EV_CW = 5;
  // widths
  localparam int CNT_W = 16;
  localparam int SENS_CW = 2;
  localparam int CUR_W = 16;
  localparam int TS_W = 32;
  localparam int SG_W = 3;
  localparam int HIST_DEPTH = 12;
  localparam int HIST_IW = 4;
  // operation record layout
  localparam int R_TS = 0;
  localparam int R_CODE = 32;
  localparam int R_IA = 37;
  localparam int R_IB = 53;
  localparam int R_IC = 69;
  localparam int R_IR = 85;
  localparam int R_SENS = 101;
  localparam int R_SG = 105;
  localparam int REC_W = 108;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
endpackage : arc_zone_pkg

/* logic/op_history.sv */
`timescale 1ns/10ps
`default_nettype none
module op_history
  import arc_zone_pkg::*;
(
  input wire logic clk_i, // program cycle clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic wr_i, // store one record
  input wire logic [REC_W-1:0] wr_data_i, // record to store
  input wire logic [HIST_IW-1:0] rd_idx_i, // 0 = newest
  output logic [REC_W-1:0] rd_data_o, // selected record, zero if absent
  output logic [HIST_IW-1:0] count_o // records held
);
  logic [REC_W-1:0] rec_mem [HIST_DEPTH];
  logic [HIST_IW-1:0] wptr_reg;
  logic [HIST_IW-1:0] cnt_reg;
  logic [HIST_IW:0] slot_sum;
  logic [HIST_IW:0] slot_mod;
  wire logic [HIST_IW-1:0] wptr_next;
  wire logic rd_valid;

  assign wptr_next = (wptr_reg == HIST_IW'(HIST_DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
  assign slot_sum = {1'b0, wptr_reg} + (HIST_IW + 1)'(HIST_DEPTH - 1) - {1'b0, rd_idx_i};
  assign slot_mod = (slot_sum >= (HIST_IW + 1)'(HIST_DEPTH)) ?
                    slot_sum - (HIST_IW + 1)'(HIST_DEPTH) : slot_sum;
  assign rd_valid = rd_idx_i < cnt_reg;
  assign rd_data_o = rd_valid ? rec_mem[slot_mod[HIST_IW-1:0]] : '0;
  assign count_o = cnt_reg;

  // (RULE_15) ring of twelve, oldest overwritten
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wptr_reg <= '0;
      cnt_reg <= '0;
    end else if (wr_i) begin
      wptr_reg <= wptr_next;
      if (cnt_reg != HIST_IW'(HIST_DEPTH)) cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // data array carries no reset; reads are masked by the fill count
  always_ff @(posedge clk_i) begin
    if (wr_i) rec_mem[wptr_reg] <= wr_data_i;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_hist_bound: assert property (cnt_reg <= HIST_IW'(HIST_DEPTH)) // RULE_15
    else $error("history holds more than twelve records");
  a_hist_full_hold: assert property (cnt_reg == HIST_IW'(HIST_DEPTH) && wr_i |=> // RULE_15
      cnt_reg == HIST_IW'(HIST_DEPTH) && rec_mem[$past(wptr_reg)] == $past(wr_data_i))
    else $error("full history did not replace oldest record");
endmodule : op_history
`default_nettype wire

/* logic/arc_zone_trip_logic.sv */
`timescale 1ns/10ps
`default_nettype none
// Operation
// (RULE_01) phase current enable gates zone trip on phase overcurrent pick-up
// (RULE_02) residual current enable gates zone trip on residual pick-up
// (RULE_03) per-zone light enable per channel lets that light trip the zone
// (RULE_04) per-zone pressure enable per channel lets that pressure trip the zone
// (RULE_05) aux selector off, light-equivalent or current-gated; light mode trips alone
// (RULE_06) current-gated mode trips only with aux and a sensor together
// (RULE_07) blocking input sampled once at each program cycle start
// (RULE_08) condition rising while unblocked asserts zone trip
// (RULE_09) condition rising while blocked asserts zone blocked, no trip
// (RULE_10) blocking source asserts at least 5 ms before operating delay ends
// (RULE_11) every monitored status change yields its own ON or OFF event; a bit that toggles twice before it is served gives one event here
// (RULE_12) per-event ON/OFF selection for buffer, each event time stamped
// (RULE_13) resettable cumulative event counter; outputs usable directly
// (RULE_14) sensor 1-4 and I/O-unit faults raise ON and OFF events
// (RULE_15) keep only twelve newest operation records, oldest dropped
// (RULE_16) record holds time, event, phase and residual currents, sensors, group
// (RULE_17) live zone trip/blocked and sensor status report
// (RULE_18) four zones, each enabled separately, disabled zone stays quiet
// (RULE_19) sensor count mismatch on a channel sets its configuration fault
// (RULE_20) nothing enabled never trips; trip falls with its condition
module arc_zone_trip_logic
  import arc_zone_pkg::*;
(
  input wire logic clk_i, // program cycle clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic [AW-1:0] addr_i, // register byte address
  input wire logic [DW-1:0] wdata_i, // register write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [DW-1:0] rdata_o, // read data, cycle after rd_i
  input wire logic cycle_start_i, // program cycle start pulse
  input wire logic block_i, // blocking input
  input wire logic ph_pickup_i, // phase overcurrent pick-up
  input wire logic res_pickup_i, // residual overcurrent pick-up
  input wire logic [NCHAN-1:0] light_i, // light per channel
  input wire logic [NCHAN-1:0] pres_i, // pressure per channel
  input wire logic aux_i, // aux binary input
  input wire logic [NCHAN*SENS_CW-1:0] sens_found_i, // sensors found per channel
  input wire logic io_fault_i, // I/O unit fault
  input wire logic [TS_W-1:0] ts_i, // time stamp in ms
  input wire logic [CUR_W-1:0] cur_a_i, // phase A current
  input wire logic [CUR_W-1:0] cur_b_i, // phase B current
  input wire logic [CUR_W-1:0] cur_c_i, // phase C current
  input wire logic [CUR_W-1:0] cur_r_i, // residual current
  input wire logic [SG_W-1:0] sg_i, // setting group in use
  output logic [NZONE-1:0] zone_trip_o, // zone trip
  output logic [NZONE-1:0] zone_blocked_o, // zone blocked
  output logic ph_start_o, // phase current start
  output logic ph_blocked_o, // phase current blocked
  output logic res_start_o, // residual current start
  output logic res_blocked_o, // residual current blocked
  output logic [EV_W-1:0] status_o, // sensor and zone status
  output logic evt_valid_o, // event to main buffer
  output logic [EV_CW-1:0] evt_code_o, // event status index
  output logic evt_on_o, // 1 = ON, 0 = OFF
  output logic [TS_W-1:0] evt_ts_o // event time stamp
);
  logic [NZONE-1:0] zone_en_reg;
  logic [CFG_W-1:0] zone_cfg_reg [NZONE];
  logic [NCHAN*SENS_CW-1:0] chan_cfg_reg;
  logic [EV_W-1:0] on_sel_reg;
  logic [EV_W-1:0] off_sel_reg;
  logic [CNT_W-1:0] evt_cnt_reg;
  logic [HIST_IW-1:0] hist_sel_reg;
  logic blk_reg;
  logic [NZONE-1:0] cond_reg;
  logic [NZONE-1:0] trip_reg;
  logic [NZONE-1:0] blocked_reg;
  logic ph_start_reg;
  logic ph_blk_reg;
  logic res_start_reg;
  logic res_blk_reg;
  logic [NCHAN-1:0] sfault_reg;
  logic [EV_W-1:0] stat_reg;
  logic [EV_W-1:0] pend_reg;
  logic evt_valid_reg;
  logic [EV_CW-1:0] evt_code_reg;
  logic evt_on_reg;
  logic [TS_W-1:0] evt_ts_reg;
  logic [DW-1:0] rdata_reg;
  logic [EV_CW-1:0] emit_idx;

  wire logic [NZONE-1:0] cond;
  wire logic [NZONE-1:0] trip_next;
  wire logic [NZONE-1:0] blocked_next;
  wire logic [NCHAN-1:0] sfault_next;
  wire logic [EV_W-1:0] stat_now;
  wire logic [EV_W-1:0] chg;
  wire logic [EV_W-1:0] emit_oh;
  wire logic [EV_W-1:0] pend_next;
  wire logic emit_any;
  wire logic emit_on;
  wire logic emit_sel;
  wire logic rec_wr;
  wire logic [REC_W-1:0] rec_in;
  wire logic [REC_W-1:0] rec_out;
  wire logic [HIST_IW-1:0] hist_cnt;
  wire logic wr_zone_en;
  wire logic wr_chan_cfg;
  wire logic wr_on_sel;
  wire logic wr_off_sel;
  wire logic cnt_clr;
  wire logic wr_hist_sel;
  wire logic [CNT_W-1:0] cnt_next;
  wire logic [DW-1:0] rd_mux;
  wire logic [DW-1:0] rd_zone_cfg [NZONE];

  assign wr_zone_en = wr_i && addr_i == A_ZONE_EN;
  assign wr_chan_cfg = wr_i && addr_i == A_CHAN_CFG;
  assign wr_on_sel = wr_i && addr_i == A_ON_SEL;
  assign wr_off_sel = wr_i && addr_i == A_OFF_SEL;
  assign cnt_clr = wr_i && addr_i == A_EVT_CNT;
  assign wr_hist_sel = wr_i && addr_i == A_HIST_SEL;

  genvar z;
  generate
    for (z = 0; z < NZONE; z++) begin : g_zone
      wire logic [CFG_W-1:0] cfg;
      wire logic light_hit;
      wire logic pres_hit;
      wire logic sens_hit;
      wire logic gate_ok;
      wire logic trig;
      wire logic rise;
      aux_mode_e aux_m;
      assign cfg = zone_cfg_reg[z];
      assign aux_m = aux_mode_e'(cfg[F_AUX +: AUX_W]);
      // (RULE_03) enabled light channels
      assign light_hit = |(light_i & cfg[F_LIGHT +: NCHAN]);
      // (RULE_04) enabled pressure channels
      assign pres_hit = |(pres_i & cfg[F_PRES +: NCHAN]);
      assign sens_hit = light_hit | pres_hit;
      // (RULE_01) phase current gate
      // (RULE_02) residual current gate
      assign gate_ok = (~cfg[F_PH] | ph_pickup_i) & (~cfg[F_RES] | res_pickup_i);
      // (RULE_05) light-equivalent aux
      // (RULE_06) current-gated aux needs a sensor too
      assign trig = (aux_m == AUX_CUR) ? (aux_i & sens_hit) :
                    (sens_hit | ((aux_m == AUX_LIGHT) & aux_i));
      // (RULE_18) disabled zone never picks up
      // (RULE_20) gates alone never trip
      assign cond[z] = zone_en_reg[z] & gate_ok & trig;
      assign rise = cond[z] & ~cond_reg[z];
      // (RULE_08) trip when unblocked at pick-up
      // (RULE_09) blocked instead, decision held for the event
      assign trip_next[z] = cond[z] & (rise ? ~blk_reg : trip_reg[z]);
      assign blocked_next[z] = cond[z] & (rise ? blk_reg : blocked_reg[z]);
      assign rd_zone_cfg[z] = {{(DW - CFG_W){1'b0}}, cfg};

      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          zone_cfg_reg[z] <= '0;
        end else if (wr_i && addr_i == A_ZONE_CFG[z]) begin
          zone_cfg_reg[z] <= wdata_i[CFG_W-1:0];
        end
      end
    end

    for (z = 0; z < NCHAN; z++) begin : g_chan
      // (RULE_19) found count against configured count
      assign sfault_next[z] = sens_found_i[z*SENS_CW +: SENS_CW] !=
                              chan_cfg_reg[z*SENS_CW +: SENS_CW];
    end
  endgenerate

  // (RULE_14) sensor and I/O-unit faults are monitored like any status
  // (RULE_11) every bit of this vector is watched for change
  assign stat_now = {io_fault_i, sfault_reg, aux_i, pres_i, light_i, res_start_reg,
                     res_blk_reg, ph_start_reg, ph_blk_reg, blocked_reg, trip_reg};
  assign chg = stat_now ^ stat_reg;

  // lowest pending index goes first; a bit that toggles twice before it is
  // served merges into one event, which only happens under event bursts
  always_comb begin
    emit_idx = '0;
    for (int i = EV_W - 1; i >= 0; i--) begin
      if (pend_reg[i]) emit_idx = EV_CW'(i);
    end
  end

  assign emit_any = |pend_reg;
  assign emit_oh = emit_any ? (EV_W'(1) << emit_idx) : '0;
  // (RULE_11) a new change wins over the serve of the same bit
  assign pend_next = (pend_reg & ~emit_oh) | chg;
  assign emit_on = stat_reg[emit_idx];
  // (RULE_12) per-event ON / OFF selection
  assign emit_sel = emit_on ? on_sel_reg[emit_idx] : off_sel_reg[emit_idx];
  // (RULE_13) counter clear still counts a same-cycle event, leaving one
  assign cnt_next = cnt_clr ? (emit_any ? CNT_ONE : '0) :
                    (emit_any ? evt_cnt_reg + CNT_ONE : evt_cnt_reg);

  // zone trip ON and zone blocked ON are the operations worth recording
  assign rec_wr = emit_any & emit_on & (emit_idx < EV_CW'(EV_PH_BLK));
  // (RULE_16) record assembly
  assign rec_in = {sg_i, light_i | pres_i, cur_r_i, cur_c_i, cur_b_i, cur_a_i,
                   emit_idx, ts_i};

  op_history u_hist (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_i(rec_wr),
    .wr_data_i(rec_in),
    .rd_idx_i(hist_sel_reg),
    .rd_data_o(rec_out),
    .count_o(hist_cnt)
  );

  // (RULE_17) status and history readback
  assign rd_mux =
    (addr_i == A_ZONE_EN) ? {{(DW - NZONE){1'b0}}, zone_en_reg} :
    (addr_i == A_ZONE_CFG[0]) ? rd_zone_cfg[0] :
    (addr_i == A_ZONE_CFG[1]) ? rd_zone_cfg[1] :
    (addr_i == A_ZONE_CFG[2]) ? rd_zone_cfg[2] :
    (addr_i == A_ZONE_CFG[3]) ? rd_zone_cfg[3] :
    (addr_i == A_CHAN_CFG) ? {{(DW - NCHAN*SENS_CW){1'b0}}, chan_cfg_reg} :
    (addr_i == A_ON_SEL) ? {{(DW - EV_W){1'b0}}, on_sel_reg} :
    (addr_i == A_OFF_SEL) ? {{(DW - EV_W){1'b0}}, off_sel_reg} :
    (addr_i == A_EVT_CNT) ? {{(DW - CNT_W){1'b0}}, evt_cnt_reg} :
    (addr_i == A_STATUS) ? {{(DW - EV_W){1'b0}}, stat_reg} :
    (addr_i == A_HIST_SEL) ? {{(DW - 2*HIST_IW){1'b0}}, hist_cnt, hist_sel_reg} :
    (addr_i == A_HIST_TS) ? rec_out[R_TS +: TS_W] :
    (addr_i == A_HIST_AB) ? {rec_out[R_IB +: CUR_W], rec_out[R_IA +: CUR_W]} :
    (addr_i == A_HIST_CR) ? {rec_out[R_IR +: CUR_W], rec_out[R_IC +: CUR_W]} :
    (addr_i == A_HIST_MISC) ? {{(DW - SG_W - NCHAN - EV_CW){1'b0}},
                               rec_out[R_SG +: SG_W], rec_out[R_SENS +: NCHAN],
                               rec_out[R_CODE +: EV_CW]} :
    '0;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      zone_en_reg <= '0;
      chan_cfg_reg <= '0;
      on_sel_reg <= '0;
      off_sel_reg <= '0;
      hist_sel_reg <= '0;
      rdata_reg <= '0;
    end else begin
      if (wr_zone_en) zone_en_reg <= wdata_i[NZONE-1:0];
      if (wr_chan_cfg) chan_cfg_reg <= wdata_i[NCHAN*SENS_CW-1:0];
      if (wr_on_sel) on_sel_reg <= wdata_i[EV_W-1:0];
      if (wr_off_sel) off_sel_reg <= wdata_i[EV_W-1:0];
      if (wr_hist_sel) hist_sel_reg <= wdata_i[HIST_IW-1:0];
      rdata_reg <= rd_i ? rd_mux : '0;
    end
  end

  // (RULE_07) blocking sampled only at cycle start
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      blk_reg <= 1'b0;
    end else if (cycle_start_i) begin
      blk_reg <= block_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cond_reg <= '0;
      trip_reg <= '0;
      blocked_reg <= '0;
      ph_start_reg <= 1'b0;
      ph_blk_reg <= 1'b0;
      res_start_reg <= 1'b0;
      res_blk_reg <= 1'b0;
      sfault_reg <= '0;
    end else begin
      cond_reg <= cond;
      trip_reg <= trip_next;
      blocked_reg <= blocked_next;
      ph_start_reg <= ph_pickup_i & ~blk_reg;
      ph_blk_reg <= ph_pickup_i & blk_reg;
      res_start_reg <= res_pickup_i & ~blk_reg;
      res_blk_reg <= res_pickup_i & blk_reg;
      sfault_reg <= sfault_next;
    end
  end

  // (RULE_12) time-stamped event to the buffer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_reg <= '0;
      pend_reg <= '0;
      evt_cnt_reg <= '0;
      evt_valid_reg <= 1'b0;
      evt_code_reg <= '0;
      evt_on_reg <= 1'b0;
      evt_ts_reg <= '0;
    end else begin
      stat_reg <= stat_now;
      pend_reg <= pend_next;
      evt_cnt_reg <= cnt_next;
      evt_valid_reg <= emit_any & emit_sel;
      evt_code_reg <= emit_idx;
      evt_on_reg <= emit_on;
      evt_ts_reg <= ts_i;
    end
  end

  assign rdata_o = rdata_reg;
  assign zone_trip_o = trip_reg;
  assign zone_blocked_o = blocked_reg;
  assign ph_start_o = ph_start_reg;
  assign ph_blocked_o = ph_blk_reg;
  assign res_start_o = res_start_reg;
  assign res_blocked_o = res_blk_reg;
  assign status_o = stat_reg;
  assign evt_valid_o = evt_valid_reg;
  assign evt_code_o = evt_code_reg;
  assign evt_on_o = evt_on_reg;
  assign evt_ts_o = evt_ts_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  wire logic ph_en0;
  wire logic res_en0;
  assign ph_en0 = zone_cfg_reg[0][F_PH];
  assign res_en0 = zone_cfg_reg[0][F_RES];

  sequence s_rise_free;
    $rose(cond[0]) && !blk_reg;
  endsequence
  sequence s_rise_held;
    $rose(cond[0]) && blk_reg;
  endsequence

  a_disabled_zone_quiet: assert property (!zone_en_reg[0] |=> // RULE_18
      !zone_trip_o[0] && !zone_blocked_o[0])
    else $error("disabled zone reported trip or blocked");
  a_trip_when_free: assert property (s_rise_free |=> // RULE_08
      zone_trip_o[0] && !zone_blocked_o[0])
    else $error("unblocked pick-up did not trip");
  a_blocked_not_trip: assert property (s_rise_held |=> // RULE_09
      zone_blocked_o[0] && !zone_trip_o[0] ##1 !zone_trip_o[0])
    else $error("blocked pick-up tripped");
  a_trip_falls: assert property (!cond[0] |=> !zone_trip_o[0] && !zone_blocked_o[0]) // RULE_20
    else $error("zone output stayed after condition fell");
  a_block_sample: assert property (!cycle_start_i |=> $stable(blk_reg)) // RULE_07
    else $error("blocking changed outside cycle start");
  a_phase_gate: assert property ($rose(zone_trip_o[0]) && $past(ph_en0) |-> // RULE_01
      $past(ph_pickup_i))
    else $error("zone tripped without phase pick-up");
  a_resid_gate: assert property ($rose(zone_trip_o[0]) && $past(res_en0) |-> // RULE_02
      $past(res_pickup_i))
    else $error("zone tripped without residual pick-up");
  a_event_count: assert property (emit_any && !cnt_clr |=> // RULE_13
      evt_cnt_reg == $past(evt_cnt_reg) + CNT_ONE)
    else $error("event counter missed an event");
  a_event_select: assert property (emit_any |=> evt_valid_o == $past(emit_sel) && // RULE_12
      evt_on_o == $past(emit_on))
    else $error("event buffer selection wrong");
  a_change_pending: assert property (chg != '0 |=> // RULE_11
      (pend_reg & $past(chg)) == $past(chg))
    else $error("status change not queued as event");
  // fault flop, then status flop: the flag shows two edges after the mismatch
  a_config_fault: assert property (sfault_next[0] |=> ##1 status_o[EV_SFAULT]) // RULE_19
    else $error("sensor count mismatch not flagged");
endmodule : arc_zone_trip_logic
`default_nettype wire

/* test/sensor_chan_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sensor_chan_model
  import arc_zone_pkg::*;
(
  input wire logic clk_i, // program cycle clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic [NCHAN-1:0] light_cmd_i, // light scene
  input wire logic [NCHAN-1:0] pres_cmd_i, // pressure scene
  input wire logic aux_cmd_i, // aux scene
  input wire logic ph_cmd_i, // phase overcurrent scene
  input wire logic res_cmd_i, // residual overcurrent scene
  input wire logic [NCHAN*SENS_CW-1:0] found_cmd_i, // sensors wired per channel
  input wire logic io_cmd_i, // I/O unit broken
  output logic [NCHAN-1:0] light_o, // light detected
  output logic [NCHAN-1:0] pres_o, // pressure detected
  output logic aux_o, // aux input level
  output logic ph_o, // phase pick-up
  output logic res_o, // residual pick-up
  output logic [NCHAN*SENS_CW-1:0] found_o, // sensors found
  output logic io_o // I/O unit fault
);
  // detections lag the scene by one cycle, like a filtered sensor channel
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {light_o, pres_o, aux_o, ph_o, res_o, found_o, io_o} <= '0;
    end else begin
      {light_o, pres_o, aux_o} <= {light_cmd_i, pres_cmd_i, aux_cmd_i};
      {ph_o, res_o} <= {ph_cmd_i, res_cmd_i};
      {found_o, io_o} <= {found_cmd_i, io_cmd_i};
    end
  end
endmodule : sensor_chan_model
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import arc_zone_pkg::*;
  typedef struct packed {logic [11:0] cfg; logic ph; logic rs; logic [3:0] lt; logic [3:0] pr;
    logic ax; logic trip;} row_s;
  row_s rows [15] = '{
    {12'h004, 2'h0, 4'h1, 4'h0, 2'h1}, {12'h020, 2'h0, 4'h8, 4'h0, 2'h1},
    {12'h020, 2'h0, 4'h1, 4'h0, 2'h0}, {12'h100, 2'h0, 4'h0, 4'h4, 2'h1},
    {12'h100, 2'h0, 4'h0, 4'h2, 2'h0}, {12'h005, 2'h0, 4'h1, 4'h0, 2'h0},
    {12'h005, 2'h2, 4'h1, 4'h0, 2'h1}, {12'h006, 2'h0, 4'h1, 4'h0, 2'h0},
    {12'h006, 2'h1, 4'h1, 4'h0, 2'h1}, {12'h400, 2'h0, 4'h0, 4'h0, 2'h3},
    {12'h800, 2'h0, 4'h0, 4'h0, 2'h2}, {12'h804, 2'h0, 4'h1, 4'h0, 2'h0},
    {12'h804, 2'h0, 4'h1, 4'h0, 2'h3}, {12'hC00, 2'h0, 4'h0, 4'h0, 2'h2},
    {12'h000, 2'h3, 4'hF, 4'hF, 2'h2}};
  logic clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, cycle_start_i = 1'b0;
  logic block_i = 1'b0, c_aux = 1'b0, c_ph = 1'b0, c_res = 1'b0, c_io = 1'b0;
  logic [AW-1:0] addr_i = '0;
  logic [DW-1:0] wdata_i = '0, rdata_o;
  // event outputs stand one cycle and zone outputs only while their condition holds, so they are caught as they stand
  logic [2*NZONE-1:0] seen;
  logic [5:0] ev_seen;
  logic [TS_W-1:0] ev_ts;
  logic [NCHAN-1:0] c_light = '0, c_pres = '0, light_i, pres_i;
  logic [NCHAN*SENS_CW-1:0] c_found = '0, sens_found_i;
  logic aux_i, ph_pickup_i, res_pickup_i, io_fault_i, ph_start_o, ph_blocked_o, res_start_o;
  logic res_blocked_o, evt_valid_o, evt_on_o;
  logic [TS_W-1:0] ts_i = '0, evt_ts_o;
  logic [CUR_W-1:0] cur_a_i = '0, cur_b_i = '0, cur_c_i = '0, cur_r_i = '0;
  logic [SG_W-1:0] sg_i = '0;
  logic [NZONE-1:0] zone_trip_o, zone_blocked_o;
  logic [EV_W-1:0] status_o;
  logic [EV_CW-1:0] evt_code_o;
  int n_fail = 0, tests_run = 0, k;
  always #20 clk_i = ~clk_i;
  sensor_chan_model sensor_chan_model_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .light_cmd_i(c_light), .pres_cmd_i(c_pres), .aux_cmd_i(c_aux), .ph_cmd_i(c_ph),
    .res_cmd_i(c_res), .found_cmd_i(c_found), .io_cmd_i(c_io), .light_o(light_i),
    .pres_o(pres_i), .aux_o(aux_i), .ph_o(ph_pickup_i), .res_o(res_pickup_i),
    .found_o(sens_found_i), .io_o(io_fault_i));
  arc_zone_trip_logic arc_zone_trip_logic_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cycle_start_i(cycle_start_i), .block_i(block_i), .ph_pickup_i(ph_pickup_i),
    .res_pickup_i(res_pickup_i), .light_i(light_i), .pres_i(pres_i), .aux_i(aux_i),
    .sens_found_i(sens_found_i), .io_fault_i(io_fault_i), .ts_i(ts_i), .cur_a_i(cur_a_i),
    .cur_b_i(cur_b_i), .cur_c_i(cur_c_i), .cur_r_i(cur_r_i), .sg_i(sg_i),
    .zone_trip_o(zone_trip_o), .zone_blocked_o(zone_blocked_o), .ph_start_o(ph_start_o),
    .ph_blocked_o(ph_blocked_o), .res_start_o(res_start_o), .res_blocked_o(res_blocked_o),
    .status_o(status_o), .evt_valid_o(evt_valid_o), .evt_code_o(evt_code_o),
    .evt_on_o(evt_on_o), .evt_ts_o(evt_ts_o));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  task automatic check_val(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check_val
  task automatic reg_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_i);
    {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : reg_wr
  task automatic reg_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge clk_i);
    {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check_val(rdata_o, exp);
  endtask : reg_chk
  // light on channel 1 for hold cycles; seen keeps {blocked, trip} as it drops
  task automatic flash(input int hold);
    @(posedge clk_i);
    c_light <= 4'h1;
    repeat (hold) @(posedge clk_i);
    c_light <= 4'h0;
    #1 seen = {zone_blocked_o, zone_trip_o};
    repeat (4) @(posedge clk_i);
  endtask : flash
  task automatic start_cycle();
    @(posedge clk_i);
    cycle_start_i <= 1'b1;
    @(posedge clk_i);
    cycle_start_i <= 1'b0;
  endtask : start_cycle
  task automatic count_evt(input int n);
    k = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1 if (evt_valid_o === 1'b1) begin
        k++;
        {ev_seen, ev_ts} = {evt_code_o, evt_on_o, evt_ts_o};
      end
    end
  endtask : count_evt
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    foreach (A_ZONE_CFG[i]) reg_chk(A_ZONE_CFG[i], '0);
    reg_wr(8'h3C, 32'hFFFFFFFF);
    reg_chk(8'h3C, '0);
    $display("test reset_and_map done");
    start_cycle();
    reg_wr(A_ZONE_EN, 32'h1);
    foreach (rows[i]) begin
      reg_wr(A_ZONE_CFG[0], {20'h0, rows[i].cfg});
      @(posedge clk_i);
      {c_ph, c_res, c_light, c_pres, c_aux} <=
        {rows[i].ph, rows[i].rs, rows[i].lt, rows[i].pr, rows[i].ax};
      repeat (4) @(posedge clk_i);
      #1 check_val(DW'(zone_trip_o), DW'(rows[i].trip));
      check_val(DW'({ph_start_o, res_start_o}), DW'({rows[i].ph, rows[i].rs}));
      @(posedge clk_i);
      {c_ph, c_res, c_light, c_pres, c_aux} <= '0;
      repeat (4) @(posedge clk_i);
      #1 check_val(DW'(zone_trip_o), '0);
      check_val(DW'({ph_start_o, res_start_o}), '0);
    end
    $display("test zone_table done");
    reg_wr(A_ZONE_CFG[0], 32'h4);
    @(posedge clk_i);
    // block raised just before the pick-up, unsampled until the next cycle start
    block_i <= 1'b1;
    flash(3);
    check_val(DW'(seen), 32'h01);
    start_cycle();
    flash(3);
    check_val(DW'(seen), 32'h10);
    @(posedge clk_i);
    {c_light, c_ph, c_res} <= {4'h1, 2'h3};
    repeat (4) @(posedge clk_i);
    #1 check_val(DW'({zone_blocked_o, zone_trip_o}), 32'h10);
    check_val(DW'({res_blocked_o, ph_blocked_o}), 32'h3);
    @(posedge clk_i);
    block_i <= 1'b0;
    {c_light, c_ph, c_res} <= '0;
    repeat (4) @(posedge clk_i);
    start_cycle();
    @(posedge clk_i);
    c_light <= 4'h1;
    repeat (4) @(posedge clk_i);
    #1 check_val(DW'({zone_blocked_o, zone_trip_o}), 32'h01);
    @(posedge clk_i);
    block_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 check_val(DW'(zone_trip_o), 32'h1);
    @(posedge clk_i);
    block_i <= 1'b0;
    c_light <= 4'h0;
    start_cycle();
    $display("test blocking done");
    reg_wr(A_ZONE_EN, 32'h8);
    reg_wr(A_ZONE_CFG[3], 32'h4);
    @(posedge clk_i);
    c_light <= 4'h1;
    repeat (4) @(posedge clk_i);
    #1 check_val(DW'(zone_trip_o), 32'h8);
    c_light <= 4'h0;
    reg_wr(A_ZONE_EN, 32'h0);
    flash(4);
    check_val(DW'(seen), '0);
    $display("test zone_enable done");
    reg_wr(A_ON_SEL, 32'h03FFFFFF);
    reg_wr(A_EVT_CNT, '0);
    ts_i <= 32'h0000ABCD;
    c_aux <= 1'b1;
    count_evt(5);
    check_val(DW'(k), 32'h1);
    check_val(DW'(ev_seen), DW'({5'(EV_AUX), 1'b1}));
    check_val(ev_ts, 32'h0000ABCD);
    c_aux <= 1'b0;
    count_evt(6);
    check_val(DW'(k), '0);
    reg_chk(A_EVT_CNT, 32'h2);
    $display("test events done");
    reg_wr(A_CHAN_CFG, 32'h1);
    c_io <= 1'b1;
    count_evt(6);
    reg_chk(A_STATUS, 32'h02200000);
    check_val(DW'(k), 32'h2);
    {c_found, c_io} <= {8'h01, 1'b0};
    count_evt(6);
    reg_chk(A_STATUS, '0);
    $display("test faults done");
    reg_wr(A_ZONE_EN, 32'h1);
    for (int i = 0; i < 13; i++) begin
      {ts_i, cur_a_i, cur_b_i, sg_i} <= {32'h00005550 + TS_W'(i), 16'h1111, 16'h2222, 3'h5};
      flash(3);
    end
    reg_wr(A_HIST_SEL, '0);
    reg_chk(A_HIST_SEL, 32'hC0);
    reg_chk(A_HIST_TS, 32'h0000555C);
    reg_chk(A_HIST_AB, 32'h22221111);
    reg_chk(A_HIST_MISC, 32'h00000A20);
    reg_wr(A_HIST_SEL, 32'hB);
    reg_chk(A_HIST_TS, 32'h00005551);
    reg_wr(A_HIST_SEL, 32'hC);
    reg_chk(A_HIST_TS, '0);
    $display("test history done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
